// *** rtl/dwm_pkg.sv ***
// constants and types shared by the mode logic of the memory device
package dwm_pkg;

	localparam int          CLOCK_PERIOD_PS      = 10000;
	// mode update delay in picoseconds, plain default
	localparam int          MODE_UPDATE_DELAY_PS = 150000;
	localparam int          MODE_UPDATE_CYCLES   = (MODE_UPDATE_DELAY_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int          MODE_REG_CYCLE_CYCLES = 8;
	localparam int          CAL_W                = 3;
	localparam int          CNT_W                = 16;

	// mode register one: leveling enable bit position
	localparam int          MR1_LEVEL_BIT        = 7;
	// mode register two: self refresh mode field
	localparam int          MR2_SREF_LO          = 6;
	localparam int          MR2_SREF_HI          = 7;
	localparam int          MR_W                 = 18;

	// self refresh thresholds in degrees celsius
	localparam logic [7:0]  TEMP_NORMAL_MAX      = 8'h55;
	localparam logic [7:0]  TEMP_EXTENDED_MAX    = 8'h5f;
	localparam logic [7:0]  TEMP_REDUCED_MAX     = 8'h2d;

	typedef enum logic [1:0] {
		DWM_SREF_NORMAL  = 2'h0,
		DWM_SREF_REDUCED = 2'h1,
		DWM_SREF_EXTENDED= 2'h2,
		DWM_SREF_AUTO    = 2'h3
	} dwm_sref_mode_e;

	// internal refresh rate codes
	typedef enum logic [1:0] {
		DWM_RATE_LOW,
		DWM_RATE_NORMAL,
		DWM_RATE_HIGH
	} dwm_rate_e;

endpackage : dwm_pkg

// *** rtl/dwm_cal_delay.sv ***
// shift line that delays the command and address by the programmed latency
`timescale 1ns/10ps
module dwm_cal_delay #(
	parameter int DATA_W = 24,
	parameter int DEPTH  = 8
) (
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic [$clog2(DEPTH)-1:0]  latency,
	input  wire logic                      in_valid,
	input  wire logic [DATA_W-1:0]         in_data,
	output logic                           out_valid,
	output logic      [DATA_W-1:0]         out_data
);
	logic [DEPTH-1:0]  vld_q;
	logic [DATA_W-1:0] dat_q [DEPTH];

	// tap 0 is the cycle chip select was registered; tap n is n clocks later
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vld_q <= '0;
		end else begin
			vld_q <= {vld_q[DEPTH-2:0], in_valid};
		end
	end

	always_ff @(posedge clock) begin
		dat_q[0] <= in_data;
		for (int i = 1; i < DEPTH; i++) begin
			dat_q[i] <= dat_q[i-1];
		end
	end

	always_comb begin
		if (latency == '0) begin
			out_valid = in_valid;
			out_data  = in_data;
		end else begin
			out_valid = vld_q[latency-1'b1];
			out_data  = dat_q[latency-1'b1];
		end
	end
endmodule : dwm_cal_delay

// *** rtl/dwm_modes.sv ***
// write leveling feedback, command address latency and self refresh mode logic
`timescale 1ns/10ps
// What this block does
// - clock level sampled on strobe drives DQ
// - no read strobe driven during leveling feedback
// - DQ undefined until mode delay after exit
// - command taken latency clocks after chip select
// - receivers on across consecutive commands
// - spacing uses newly programmed latency
// - termination timing unaffected by latency
// - auto mode tracks temperature with rate
// - decode self refresh field 00/10/01/11
// - leveling follows mode register one bit
// - leveling ODT switches strobe termination only
module dwm_modes
	import dwm_pkg::*;
#(
	parameter int CAL_DEPTH = 8,
	parameter int DQ_W      = 8
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 cs_n,
	input  wire logic                 mrs_cmd,
	input  wire logic [1:0]           mrs_sel,
	input  wire logic [MR_W-1:0]      cmd_addr,
	input  wire logic                 cal_enable,
	input  wire logic [CAL_W-1:0]     cal_clocks,
	input  wire logic                 ck_level,
	input  wire logic                 strobe_rise,
	input  wire logic                 odt,
	input  wire logic                 sref_active,
	input  wire logic [7:0]           temperature,
	output logic                      cmd_valid,
	output logic [1+2+MR_W-1:0]       cmd_data,
	output logic                      ca_rcv_on,
	output logic                      level_mode,
	output logic [DQ_W-1:0]           dq_out,
	output logic [DQ_W-1:0]           dq_oe,
	output logic                      dq_defined,
	output logic                      strobe_oe,
	output logic                      strobe_term_on,
	output logic                      dq_term_on,
	output logic                      mode_busy,
	output dwm_rate_e                 sref_rate,
	output dwm_sref_mode_e            sref_mode
);
	import dwm_pkg::*;

	localparam int TOT_W = 1 + 2 + MR_W;

	logic               lat_valid;
	logic [TOT_W-1:0]   lat_data;
	logic               lat_mrs;
	logic [1:0]         lat_sel;
	logic [MR_W-1:0]    lat_addr;
	logic [CAL_W-1:0]   cal_eff;
	logic               cs_low_q;
	logic               level_q;
	logic               fb_q;
	logic [CNT_W-1:0]   undef_cnt_q;
	logic [CNT_W-1:0]   busy_cnt_q;
	logic [CAL_W-1:0]   cal_prog_q;
	logic               cal_en_q;
	dwm_sref_mode_e     sref_mode_q;
	dwm_rate_e          rate_q;

	//////////////////////////////////////////////////////////////////////////
	// command address latency
	assign cal_eff = cal_en_q ? cal_prog_q : '0;

	dwm_cal_delay #(
		.DATA_W (TOT_W),
		.DEPTH  (CAL_DEPTH)
	) u_delay (
		.clock     (clock),
		.rst_n     (rst_n),
		.latency   (cal_eff),
		.in_valid  (!cs_n),
		.in_data   ({mrs_cmd, mrs_sel, cmd_addr}),
		.out_valid (lat_valid),
		.out_data  (lat_data)
	);
	assign {lat_mrs, lat_sel, lat_addr} = lat_data;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid <= 1'b0;
			cmd_data  <= '0;
		end else begin
			cmd_valid <= lat_valid;
			cmd_data  <= lat_data;
		end
	end

	// receivers stay on while chip select is low, one clock after, and while the delayed command is valid; always on with latency off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cs_low_q <= 1'b0;
		end else begin
			cs_low_q <= !cs_n;
		end
	end
	assign ca_rcv_on = !cal_en_q || !cs_n || cs_low_q || lat_valid;

	// latency settings come from the controller ports but only take on an mrs to register one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cal_en_q   <= 1'b0;
			cal_prog_q <= '0;
		end else if (lat_valid && lat_mrs && lat_sel == 2'h1) begin
			cal_en_q   <= cal_enable;
			cal_prog_q <= cal_clocks;
		end
	end

	// busy window after a mode command, sized from the new latency value
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_q <= '0;
		end else if (lat_valid && lat_mrs) begin
			busy_cnt_q <= CNT_W'(MODE_UPDATE_CYCLES)
				+ (cal_enable ? CNT_W'(cal_clocks) : CNT_W'(0));
		end else if (busy_cnt_q != '0) begin
			busy_cnt_q <= busy_cnt_q - 1'b1;
		end
	end
	assign mode_busy = busy_cnt_q != '0;

	//////////////////////////////////////////////////////////////////////////
	// write leveling
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else if (lat_valid && lat_mrs && lat_sel == 2'h1) begin
			level_q <= lat_addr[MR1_LEVEL_BIT];
		end
	end
	assign level_mode = level_q;

	// sampled level held until the next rising strobe or exit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fb_q <= 1'b0;
		end else if (!level_q) begin
			fb_q <= 1'b0;
		end else if (strobe_rise) begin
			fb_q <= ck_level;
		end
	end

	// after an exit mrs, dq is undefined for the mode update delay
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			undef_cnt_q <= '0;
		end else if (lat_valid && lat_mrs && lat_sel == 2'h1 && level_q && !lat_addr[MR1_LEVEL_BIT]) begin
			undef_cnt_q <= CNT_W'(MODE_UPDATE_CYCLES);
		end else if (undef_cnt_q != '0) begin
			undef_cnt_q <= undef_cnt_q - 1'b1;
		end
	end

	assign dq_out     = {DQ_W{fb_q}};
	assign dq_oe      = {DQ_W{level_q}};
	assign dq_defined = level_q || undef_cnt_q == '0;
	assign strobe_oe  = 1'b0;
	// odt timing is applied by the external pipe unchanged by latency
	assign strobe_term_on = odt;
	assign dq_term_on     = odt && !level_q;

	//////////////////////////////////////////////////////////////////////////
	// self refresh mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sref_mode_q <= DWM_SREF_NORMAL;
		end else if (lat_valid && lat_mrs && lat_sel == 2'h2 && !sref_active) begin
			sref_mode_q <= dwm_sref_mode_e'(lat_addr[MR2_SREF_HI:MR2_SREF_LO]);
		end
	end
	assign sref_mode = sref_mode_q;

	// rate fixed at entry in manual modes; auto mode tracks temperature
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rate_q <= DWM_RATE_NORMAL;
		end else if (sref_mode_q == DWM_SREF_AUTO) begin
			if (temperature > TEMP_NORMAL_MAX) begin
				rate_q <= DWM_RATE_HIGH;
			end else if (temperature <= TEMP_REDUCED_MAX) begin
				rate_q <= DWM_RATE_LOW;
			end else begin
				rate_q <= DWM_RATE_NORMAL;
			end
		end else if (!sref_active) begin
			unique case (sref_mode_q)
				DWM_SREF_NORMAL:   rate_q <= DWM_RATE_NORMAL;
				DWM_SREF_EXTENDED: rate_q <= DWM_RATE_HIGH;
				DWM_SREF_REDUCED:  rate_q <= DWM_RATE_LOW;
				DWM_SREF_AUTO:     rate_q <= DWM_RATE_NORMAL;
			endcase
		end
	end
	assign sref_rate = rate_q;

	//////////////////////////////////////////////////////////////////////////
	// checks
	a_feedback_hold: assert property (@(posedge clock) disable iff (!rst_n)
		level_q && !strobe_rise |=> fb_q == $past(fb_q)) else $error("feedback changed without strobe");
	a_feedback_take: assert property (@(posedge clock) disable iff (!rst_n)
		level_q && strobe_rise |=> dq_out[0] == $past(ck_level) || !level_q) else $error("feedback not sampled");
	a_no_strobe: assert property (@(posedge clock) disable iff (!rst_n)
		level_q |-> !strobe_oe) else $error("strobe driven in leveling");
	a_dq_term_off: assert property (@(posedge clock) disable iff (!rst_n)
		level_q |-> !dq_term_on) else $error("dq termination in leveling");
	a_cal_zero: assert property (@(posedge clock) disable iff (!rst_n)
		!cal_en_q && !cs_n |-> lat_valid) else $error("command not immediate");
	a_rcv_on_run: assert property (@(posedge clock) disable iff (!rst_n)
		!cs_n |-> ca_rcv_on) else $error("receivers off in command run");
	a_busy_load: assert property (@(posedge clock) disable iff (!rst_n)
		lat_valid && lat_mrs |=> busy_cnt_q == CNT_W'(MODE_UPDATE_CYCLES)
			+ ($past(cal_enable) ? CNT_W'($past(cal_clocks)) : CNT_W'(0))) else $error("busy window wrong");
	a_undef_window: assert property (@(posedge clock) disable iff (!rst_n)
		level_q && lat_valid && lat_mrs && lat_sel == 2'h1 && !lat_addr[MR1_LEVEL_BIT]
			|=> !dq_defined [*2]) else $error("dq defined too early");
	a_sref_hold: assert property (@(posedge clock) disable iff (!rst_n)
		sref_active && $past(sref_active) && sref_mode_q != DWM_SREF_AUTO |-> $stable(rate_q))
		else $error("rate changed in self refresh");
	c_level_feedback: cover property (@(posedge clock) disable iff (!rst_n) level_q && strobe_rise && ck_level);
	c_cal_cmd: cover property (@(posedge clock) disable iff (!rst_n) cal_en_q && lat_valid);
	c_auto_high: cover property (@(posedge clock) disable iff (!rst_n) sref_mode_q == DWM_SREF_AUTO && rate_q == DWM_RATE_HIGH);
endmodule : dwm_modes

// *** testbench/dwm_ctl_model.sv ***
// behavioural memory controller: command slots, leveling strobe and termination pin
`timescale 1ns/10ps
module dwm_ctl_model (
	input  wire logic        clock,
	output logic             cs_n,
	output logic             mrs_cmd,
	output logic [1:0]       mrs_sel,
	output logic [17:0]      cmd_addr,
	output logic             cal_enable,
	output logic [2:0]       cal_clocks,
	output logic             ck_level,
	output logic             strobe_rise,
	output logic             odt
);
	initial begin
		cs_n = 1'h1;
		{mrs_cmd, mrs_sel, cmd_addr, cal_enable, cal_clocks} = '0;
		{ck_level, strobe_rise, odt} = '0;
	end
	////////////////////////////////////////////////////////////////////////////
	// one slot, then the released bus shows the inverse so nothing stale passes
	task automatic cmd(input logic m, input logic [1:0] s, input logic [17:0] a);
		@(negedge clock);
		{cs_n, mrs_cmd, mrs_sel, cmd_addr} = {1'h0, m, s, a};
		@(negedge clock);
		{cs_n, mrs_cmd, mrs_sel, cmd_addr} = {1'h1, ~m, ~s, ~a};
	endtask : cmd
	// latency in whole clocks, held as configuration
	task automatic set_cal(input logic e, input logic [2:0] c);
		{cal_enable, cal_clocks} = {e, c};
	endtask : set_cal
	// single rising strobe edge; the bench calls it only once busy has cleared
	task automatic pulse(input logic lvl);
		@(negedge clock);
		{ck_level, strobe_rise} = {lvl, 1'h1};
		@(negedge clock);
		{ck_level, strobe_rise} = {~lvl, 1'h0};
	endtask : pulse
	task automatic set_odt(input logic v);
		@(negedge clock);
		odt = v;
	endtask : set_odt
endmodule : dwm_ctl_model

// *** testbench/tb.sv ***
// self-checking bench of the leveling, latency and self refresh mode logic
`timescale 1ns/10ps
module tb;
	import dwm_pkg::*;
	logic clock = 1'h0;
	logic rst_n, cs_n, mrs_cmd, cal_enable, ck_level, strobe_rise, odt, sref_active;
	logic cmd_valid, ca_rcv_on, level_mode, dq_defined, strobe_oe, strobe_term_on, dq_term_on, mode_busy;
	logic [1:0]  mrs_sel;
	logic [17:0] cmd_addr;
	logic [2:0]  cal_clocks;
	logic [7:0]  temperature, dq_out, dq_oe;
	logic [20:0] cmd_data;
	dwm_rate_e      sref_rate;
	dwm_sref_mode_e sref_mode;
	int          failures, compares, cur, k;
	logic [31:0] seed = 32'h4b;
	logic [3:0]  lt [5] = '{4'h8, 4'hb, 4'h7, 4'hf, 4'ha};
	logic [7:0]  tt [6] = '{8'h2d, 8'h2e, 8'h55, 8'h56, 8'h00, 8'hff};
	always #5 clock = ~clock;
	dwm_modes #(.CAL_DEPTH(8), .DQ_W(8)) dut (
		.clock          (clock),
		.rst_n          (rst_n),
		.cs_n           (cs_n),
		.mrs_cmd        (mrs_cmd),
		.mrs_sel        (mrs_sel),
		.cmd_addr       (cmd_addr),
		.cal_enable     (cal_enable),
		.cal_clocks     (cal_clocks),
		.ck_level       (ck_level),
		.strobe_rise    (strobe_rise),
		.odt            (odt),
		.sref_active    (sref_active),
		.temperature    (temperature),
		.cmd_valid      (cmd_valid),
		.cmd_data       (cmd_data),
		.ca_rcv_on      (ca_rcv_on),
		.level_mode     (level_mode),
		.dq_out         (dq_out),
		.dq_oe          (dq_oe),
		.dq_defined     (dq_defined),
		.strobe_oe      (strobe_oe),
		.strobe_term_on (strobe_term_on),
		.dq_term_on     (dq_term_on),
		.mode_busy      (mode_busy),
		.sref_rate      (sref_rate),
		.sref_mode      (sref_mode)
	);
	dwm_ctl_model ctl (
		.clock       (clock),
		.cs_n        (cs_n),
		.mrs_cmd     (mrs_cmd),
		.mrs_sel     (mrs_sel),
		.cmd_addr    (cmd_addr),
		.cal_enable  (cal_enable),
		.cal_clocks  (cal_clocks),
		.ck_level    (ck_level),
		.strobe_rise (strobe_rise),
		.odt         (odt)
	);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic dwm_rate_e exp_rate(input logic [7:0] t);
		if (t > TEMP_NORMAL_MAX) return DWM_RATE_HIGH;
		if (t <= TEMP_REDUCED_MAX) return DWM_RATE_LOW;
		return DWM_RATE_NORMAL;
	endfunction : exp_rate
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	// manual modes give a fixed rate; auto follows temperature
	function automatic dwm_rate_e exp_mode_rate(input int m, input logic [7:0] t);
		if (m == 0) return DWM_RATE_NORMAL;
		if (m == 1) return DWM_RATE_LOW;
		if (m == 2) return DWM_RATE_HIGH;
		return exp_rate(t);
	endfunction : exp_mode_rate
	// controller honours the spacing after a mode command before any next command
	task automatic wait_idle();
		for (int n = 0; n < 200 && mode_busy !== 1'h0; n++) @(negedge clock);
	endtask : wait_idle
	// counts negedges from the one where chip select is released, bounded
	task automatic wait_cmd();
		k = 0;
		while (cmd_valid !== 1'h1 && k < 20) begin
			k++;
			@(negedge clock);
		end
	endtask : wait_cmd
	// controller side: spacing after a mode command is honoured by waiting for busy
	task automatic mrs(input logic [1:0] s, input logic [17:0] a);
		wait_idle();
		ctl.cmd(1'h1, s, a);
		wait_cmd();
		chk("mrs_latency", cur, k);
		chk("mrs_data", {1'h1, s, a}, cmd_data);
	endtask : mrs
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	initial begin
		{rst_n, sref_active, temperature} = '0;
		{failures, compares, cur} = '0;
		tt[5] = rnd();
		repeat (4) @(posedge clock);
		@(negedge clock) rst_n = 1'h1;
		chk("level_rst", 1'h0, level_mode);
		chk("sref_rst", DWM_SREF_NORMAL, sref_mode);
		for (int i = 0; i < 5; i++) begin
			ctl.set_cal(lt[i][3], lt[i][2:0]);
			mrs(2'h1, 18'h0);
			cur = lt[i][3] ? int'(lt[i][2:0]) : 0;
			seed = rnd();
			wait_idle();
			ctl.cmd(1'h0, 2'h0, seed[17:0]);
			wait_cmd();
			chk("cmd_latency", cur, k);
			chk("cmd_data", {3'h0, seed[17:0]}, cmd_data);
		end
		ctl.set_odt(1'h1);
		mrs(2'h1, 18'h80);
		chk("level_mode", 1'h1, level_mode);
		chk("dq_oe", 8'hff, dq_oe);
		chk("strobe_oe", 1'h0, strobe_oe);
		chk("dq_term", 1'h0, dq_term_on);
		chk("strobe_term", 1'h1, strobe_term_on);
		wait_idle();
		for (int i = 0; i < 6; i++) begin
			seed = (i < 2) ? i : rnd();
			ctl.pulse(seed[0]);
			chk("dq_out", {8{seed[0]}}, dq_out);
			repeat (3) @(negedge clock);
			chk("dq_hold", {8{seed[0]}}, dq_out);
			chk("strobe_off", 1'h0, strobe_oe);
		end
		ctl.set_odt(1'h0);
		mrs(2'h1, 18'h0);
		chk("level_exit", 1'h0, level_mode);
		chk("dq_undef", 1'h0, dq_defined);
		repeat (MODE_UPDATE_CYCLES + 1) @(negedge clock);
		chk("dq_defined", 1'h1, dq_defined);
		ctl.set_odt(1'h1);
		@(negedge clock);
		chk("dq_term_norm", 1'h1, dq_term_on);
		ctl.set_odt(1'h0);
		for (int m = 0; m < 4; m++) begin
			mrs(2'h2, {10'h0, m[1:0], 6'h0});
			@(negedge clock);
			chk("sref_mode", m, sref_mode);
			chk("sref_fixed_rate", exp_mode_rate(m, temperature), sref_rate);
		end
		for (int i = 0; i < 6; i++) begin
			temperature = tt[i];
			repeat (2) @(negedge clock);
			chk("sref_rate", exp_rate(tt[i]), sref_rate);
		end
		// a selection change inside self refresh must be ignored
		sref_active = 1'h1;
		mrs(2'h2, 18'h40);
		@(negedge clock);
		chk("sref_locked", DWM_SREF_AUTO, sref_mode);
		sref_active = 1'h0;
		end_sim();
	end
endmodule : tb
